// >>> src/liu_tx_cfg.svh
`ifndef LIU_TX_CFG_SVH
`define LIU_TX_CFG_SVH

// ------------------------------------------------------------
// sampling edge and rail mode
// ------------------------------------------------------------
`define LIU_EDGE_RISING 1'b1
`define LIU_EDGE_FALLING 1'b0
`define LIU_EDGE_RESET 1'b0
`define LIU_DUAL_RESET 1'b0

// ------------------------------------------------------------
// field positions of the crossed configuration word
// ------------------------------------------------------------
`define LIU_CFG_EDGE_BIT 1
`define LIU_CFG_DUAL_BIT 0
`define LIU_CFG_RESET 2'h0

// ------------------------------------------------------------
// symbol counter
// ------------------------------------------------------------
`define LIU_SYM_CNT_W 16

`endif

// >>> src/liu_tx_pkg.sv
package liu_tx_pkg;

   typedef struct packed {
      logic pos;
      logic neg;
   } rail_pair_t;

   typedef struct packed {
      rail_pair_t fall;
   } fall_state_t;

   typedef struct packed {
      logic rst_meta;
      logic rst_sync;
      logic ce_meta;
      logic ce_sync;
      logic [1:0] cfg_meta;
      logic [1:0] cfg_sync;
      logic tip;
      logic ring;
      logic sym_toggle;
   } link_state_t;

   typedef struct packed {
      logic cfg_rising;
      logic cfg_dual;
      logic tog_meta;
      logic tog_sync;
      logic tog_prev;
      logic [15:0] symbol_count;
   } core_state_t;

endpackage

// >>> src/rail_capture_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rail_capture_if;
   logic rst;
   logic ce;
   liu_tx_pkg::rail_pair_t fall;

   modport src (
      input rst,
      input ce,
      output fall
   );

   modport dst (
      output rst,
      output ce,
      input fall
   );
endinterface // rail_capture_if

`default_nettype wire

// >>> src/rail_fall_sampler.sv
`timescale 1ns/1ps
`default_nettype none
`include "liu_tx_cfg.svh"

module rail_fall_sampler (
   input wire logic tck,
   input wire logic pos_in,
   input wire logic neg_in,
   rail_capture_if.src cap
);

   liu_tx_pkg::fall_state_t st;
   liu_tx_pkg::fall_state_t next_st;

   // ------------------------------------------------------------
   // falling-edge capture of both rails
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (cap.ce) begin
         next_st.fall.pos = pos_in;
         next_st.fall.neg = neg_in;
      end
      if (cap.rst) begin
         next_st = '0;
      end
   end

   always_ff @(negedge tck) begin
      st <= next_st;
   end

   assign cap.fall = st.fall;

endmodule // rail_fall_sampler

`default_nettype wire

// >>> src/liu_tx_terminal_input.sv
// Contract
// - After reset both rails are captured on the falling transmit edge.
// - In host mode a setting picks rising or falling capture for both rails.
// - A captured one on the positive rail gives a positive line pulse unless the negative rail also holds a one in dual-rail mode.
// - In dual-rail mode a captured one on the negative rail gives a negative line pulse unless the positive rail is also one.
// - In single-rail mode the negative rail sample is forced low inside the core.
// - In dual-rail mode the negative rail is sampled as negative-rail data.
// - Tip and ring are never high together and carry the bipolar signal.
`timescale 1ns/1ps
`default_nettype none
`include "liu_tx_cfg.svh"

module liu_tx_terminal_input #(
   parameter int SYM_CNT_W = `LIU_SYM_CNT_W
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic HOST_MODE,
   input wire logic SAMPLE_RISING_EDGE,
   input wire logic DUAL_RAIL,
   input wire logic TX_LINE_CLOCK_IN,
   input wire logic POS_RAIL_DATA_IN,
   input wire logic NEG_RAIL_DATA_IN,
   output logic LINE_TIP_OUT,
   output logic LINE_RING_OUT,
   output logic [SYM_CNT_W-1:0] SYMBOL_COUNT
);

   liu_tx_pkg::core_state_t core;
   liu_tx_pkg::core_state_t next_core;
   liu_tx_pkg::link_state_t link;
   liu_tx_pkg::link_state_t next_link;
   liu_tx_pkg::rail_pair_t sample;

   rail_capture_if cap ();

   // ------------------------------------------------------------
   // falling-edge capture stage
   // ------------------------------------------------------------
   rail_fall_sampler u_fall (
      .tck(TX_LINE_CLOCK_IN),
      .pos_in(POS_RAIL_DATA_IN),
      .neg_in(NEG_RAIL_DATA_IN),
      .cap(cap.src)
   );

   assign cap.rst = link.rst_sync;
   assign cap.ce = link.ce_sync;

   // ------------------------------------------------------------
   // system clock domain
   // ------------------------------------------------------------
   always_comb begin
      next_core = core;
      if (CE) begin
         next_core.cfg_rising = HOST_MODE & SAMPLE_RISING_EDGE;
         next_core.cfg_dual = DUAL_RAIL;
         next_core.tog_meta = link.sym_toggle;
         next_core.tog_sync = core.tog_meta;
         next_core.tog_prev = core.tog_sync;
         if (core.tog_sync != core.tog_prev) begin
            next_core.symbol_count = core.symbol_count + 16'h0001;
         end
      end
      if (SRST) begin
         next_core = '0;
         next_core.cfg_rising = `LIU_EDGE_RESET;
         next_core.cfg_dual = `LIU_DUAL_RESET;
      end
   end

   always_ff @(posedge CLK) begin
      core <= next_core;
   end

   // ------------------------------------------------------------
   // link clock domain
   // ------------------------------------------------------------
   // sync stages keep running while frozen, else ce could never return
   always_comb begin
      next_link = link;
      sample = '0;
      next_link.rst_meta = SRST;
      next_link.rst_sync = link.rst_meta;
      next_link.ce_meta = CE;
      next_link.ce_sync = link.ce_meta;
      next_link.cfg_meta = {core.cfg_rising, core.cfg_dual};
      next_link.cfg_sync = link.cfg_meta;
      if (link.cfg_sync[`LIU_CFG_EDGE_BIT] == `LIU_EDGE_RISING) begin
         sample.pos = POS_RAIL_DATA_IN;
         sample.neg = NEG_RAIL_DATA_IN;
      end else begin
         sample = cap.fall;
      end
      if (!link.cfg_sync[`LIU_CFG_DUAL_BIT]) begin
         sample.neg = 1'b0;
      end
      if (link.ce_sync) begin
         next_link.tip = sample.pos & ~sample.neg;
         next_link.ring = sample.neg & ~sample.pos;
         next_link.sym_toggle = ~link.sym_toggle;
      end
      if (link.rst_sync) begin
         next_link.cfg_meta = `LIU_CFG_RESET;
         next_link.cfg_sync = `LIU_CFG_RESET;
         next_link.tip = 1'b0;
         next_link.ring = 1'b0;
         next_link.sym_toggle = 1'b0;
      end
   end

   always_ff @(posedge TX_LINE_CLOCK_IN) begin
      link <= next_link;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // mutually exclusive tip and ring, both low for a zero
   assign LINE_TIP_OUT = link.tip;
   assign LINE_RING_OUT = link.ring;
   assign SYMBOL_COUNT = core.symbol_count[SYM_CNT_W-1:0];

endmodule // liu_tx_terminal_input

`default_nettype wire

// >>> sim/liu_tx_terminal_input_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module liu_tx_checker (
   input wire logic SRST,
   input wire logic HOST_MODE,
   input wire logic SAMPLE_RISING_EDGE,
   input wire logic DUAL_RAIL,
   input wire logic TX_LINE_CLOCK_IN,
   input wire logic POS_RAIL_DATA_IN,
   input wire logic NEG_RAIL_DATA_IN,
   input wire logic LINE_TIP_OUT,
   input wire logic LINE_RING_OUT
);
   logic fp;
   logic fn;
   wire rise = HOST_MODE & SAMPLE_RISING_EDGE;
   wire [1:0] seen = {LINE_TIP_OUT, LINE_RING_OUT};
   // both rails high is a zero symbol in dual-rail mode, a positive pulse in single-rail mode
   wire [1:0] ef = {fp & ~(fn & DUAL_RAIL), fn & DUAL_RAIL & ~fp};
   wire rp = POS_RAIL_DATA_IN;
   wire rn = NEG_RAIL_DATA_IN & DUAL_RAIL;
   wire [1:0] er = {rp & ~rn, rn & ~rp};
   always_ff @(negedge TX_LINE_CLOCK_IN) begin
      fp <= POS_RAIL_DATA_IN;
      fn <= NEG_RAIL_DATA_IN;
   end
   default clocking @(posedge TX_LINE_CLOCK_IN); endclocking
   default disable iff (SRST);
   property p_fall; !rise |-> seen == $past(ef); endproperty
   a_fall: assert property (p_fall) else $error("fall");
   property p_rise; rise |-> seen == $past(er); endproperty
   a_rise: assert property (p_rise) else $error("rise");
   property p_pos; !rise && $past(ef[1]) |-> LINE_TIP_OUT; endproperty
   a_pos: assert property (p_pos) else $error("pos");
   property p_neg; rise && $past(er == 2'h1) |-> LINE_RING_OUT; endproperty
   a_neg: assert property (p_neg) else $error("neg");
   property p_one; !rise && LINE_TIP_OUT |-> $past(fp); endproperty
   a_one: assert property (p_one) else $error("extra");
   property p_single; !DUAL_RAIL [*8] |-> !LINE_RING_OUT; endproperty
   a_single: assert property (p_single) else $error("single");
   property p_dual; DUAL_RAIL && !rise && $past(ef == 2'h1) |-> seen == 2'h1;
   endproperty
   a_dual: assert property (p_dual) else $error("dual");
   property p_excl; !(LINE_TIP_OUT && LINE_RING_OUT); endproperty
   a_excl: assert property (p_excl) else $error("both");
   c_pos: cover property (LINE_TIP_OUT && !rise);
   c_neg: cover property (LINE_RING_OUT);
   c_rise: cover property (rise && LINE_TIP_OUT);
endmodule // liu_tx_checker
bind liu_tx_terminal_input liu_tx_checker u_check (
   .SRST(SRST),
   .HOST_MODE(HOST_MODE),
   .SAMPLE_RISING_EDGE(SAMPLE_RISING_EDGE),
   .DUAL_RAIL(DUAL_RAIL),
   .TX_LINE_CLOCK_IN(TX_LINE_CLOCK_IN),
   .POS_RAIL_DATA_IN(POS_RAIL_DATA_IN),
   .NEG_RAIL_DATA_IN(NEG_RAIL_DATA_IN),
   .LINE_TIP_OUT(LINE_TIP_OUT),
   .LINE_RING_OUT(LINE_RING_OUT)
);
`default_nettype wire

// >>> sim/term_model.sv
`timescale 1ns/1ps
`default_nettype none
module term_model (
   input wire logic rise,
   input wire logic [1:0] sym,
   output logic tck,
   output logic pos,
   output logic neg
);
   initial tck = 1'h0;
   initial pos = 1'h0;
   initial neg = 1'h0;
   always #3 tck = ~tck;
   always @(tck) if (tck != rise) {pos, neg} <= sym;
endmodule // term_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic CLK = 1'h0;
   logic SRST = 1'h1;
   logic CE = 1'h1;
   logic HOST_MODE = 1'h0;
   logic SAMPLE_RISING_EDGE = 1'h0;
   logic DUAL_RAIL = 1'h0;
   logic [1:0] sym = 2'h0;
   wire TX_LINE_CLOCK_IN;
   wire POS_RAIL_DATA_IN;
   wire NEG_RAIL_DATA_IN;
   wire LINE_TIP_OUT;
   wire LINE_RING_OUT;
   wire [15:0] SYMBOL_COUNT;
   int error_cnt = 0;
   int check_count = 0;
   always #4 CLK = ~CLK;
   term_model tm (
      .rise(HOST_MODE & SAMPLE_RISING_EDGE),
      .sym(sym),
      .tck(TX_LINE_CLOCK_IN),
      .pos(POS_RAIL_DATA_IN),
      .neg(NEG_RAIL_DATA_IN)
   );
   liu_tx_terminal_input dut (
      .CLK(CLK),
      .SRST(SRST),
      .CE(CE),
      .HOST_MODE(HOST_MODE),
      .SAMPLE_RISING_EDGE(SAMPLE_RISING_EDGE),
      .DUAL_RAIL(DUAL_RAIL),
      .TX_LINE_CLOCK_IN(TX_LINE_CLOCK_IN),
      .POS_RAIL_DATA_IN(POS_RAIL_DATA_IN),
      .NEG_RAIL_DATA_IN(NEG_RAIL_DATA_IN),
      .LINE_TIP_OUT(LINE_TIP_OUT),
      .LINE_RING_OUT(LINE_RING_OUT),
      .SYMBOL_COUNT(SYMBOL_COUNT)
   );
   task automatic chk(input string nm, input logic [1:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s exp %b seen %b", nm, exp, seen);
      end
   endtask
   // answer due at the first link rise after launch; a wrong edge is late
   task automatic snd(input logic [1:0] s, e);
      @(posedge CLK) sym <= s;
      wait ({POS_RAIL_DATA_IN, NEG_RAIL_DATA_IN} == s);
      @(posedge TX_LINE_CLOCK_IN);
      #1 chk("line", {LINE_TIP_OUT, LINE_RING_OUT}, e);
      @(posedge CLK) sym <= 2'h0;
      repeat (4) @(posedge TX_LINE_CLOCK_IN);
      #1 chk("idle", {LINE_TIP_OUT, LINE_RING_OUT}, 2'h0);
   endtask
   // mode changes only while the rails idle
   task automatic mode(input logic h, r, d);
      @(posedge CLK);
      HOST_MODE <= h;
      SAMPLE_RISING_EDGE <= r;
      DUAL_RAIL <= d;
      repeat (8) @(posedge CLK);
   endtask
   task automatic t_single;
      snd(2'h2, 2'h2);
      snd(2'h1, 2'h0);
      $display("single rail done");
   endtask
   task automatic t_dual;
      mode(1'h0, 1'h0, 1'h1);
      snd(2'h1, 2'h1);
      snd(2'h3, 2'h0);
      snd(2'h2, 2'h2);
      $display("dual rail done");
   endtask
   task automatic t_rise;
      mode(1'h1, 1'h1, 1'h1);
      snd(2'h2, 2'h2);
      snd(2'h1, 2'h1);
      mode(1'h0, 1'h1, 1'h1);
      snd(2'h1, 2'h1);
      $display("edge select done");
   endtask
   // rails idle while frozen, so the line must stay quiet too
   task automatic t_hold;
      logic [15:0] c0;
      @(posedge CLK) CE <= 1'h0;
      repeat (4) @(posedge CLK);
      #1 c0 = SYMBOL_COUNT;
      repeat (16) @(posedge CLK);
      #1 chk("hold", {1'h0, SYMBOL_COUNT == c0}, 2'h1);
      chk("hold line", {LINE_TIP_OUT, LINE_RING_OUT}, 2'h0);
      @(posedge CLK) CE <= 1'h1;
      repeat (8) @(posedge CLK);
      $display("hold done");
   endtask
   task automatic t_count;
      logic [15:0] c0;
      c0 = SYMBOL_COUNT;
      repeat (16) @(posedge CLK);
      #1 chk("count", {1'h0, SYMBOL_COUNT != c0}, 2'h1);
      $display("count done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 1'h0;
      repeat (4) @(posedge CLK);
      t_single;
      t_dual;
      t_rise;
      t_hold;
      t_count;
      end_sim;
   end
   initial begin
      #20000;
      error_cnt++;
      end_sim;
   end
endmodule // tb
`default_nettype wire
